// *** logic/klirq_pkg.sv ***
// Shared constants for the keyboard line interrupt unit
package klirq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0]  KLIRQ_IDX_LEVEL   = 8'h9c; // Level select
    localparam logic [7:0]  KLIRQ_IDX_ENABLE  = 8'h9d; // Per-line enables
    localparam logic [7:0]  KLIRQ_IDX_FLAGS   = 8'h9e; // Line event flags
    localparam logic [7:0]  KLIRQ_IDX_STATUS  = 8'ha0; // Sticky events, W1C
    localparam logic [7:0]  KLIRQ_IDX_MASK    = 8'ha1; // Event mask
    localparam logic [7:0]  KLIRQ_IDX_CONTROL = 8'ha2; // Global enable
    localparam logic [7:0]  KLIRQ_IDX_LINES   = 8'ha3; // Synced pin state

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  KLIRQ_RST_LEVEL   = 8'h00;
    localparam logic [7:0]  KLIRQ_RST_ENABLE  = 8'h00;
    localparam logic [7:0]  KLIRQ_RST_FLAGS   = 8'h00;
    localparam logic [1:0]  KLIRQ_RST_EVENTS  = 2'h0;
    localparam logic        KLIRQ_RST_GLOBAL  = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int          KLIRQ_SW_CLR_LINE = 2;  // Flag cleared by software
    localparam int          KLIRQ_EV_REQ      = 0;  // Request rose
    localparam int          KLIRQ_EV_WAKE     = 1;  // Wake rose
    localparam int          KLIRQ_CTL_GLOBAL  = 0;  // Global enable bit
    localparam int          KLIRQ_SYNC_STAGES = 2;  // Pin synchroniser depth

    ////////////////////////////////////////////////////////////////////////
    // Bus answers
    localparam logic [1:0]  KLIRQ_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  KLIRQ_RESP_SLVERR = 2'h2;

endpackage

// *** logic/klirq_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for a bundle of asynchronous pins
module klirq_sync
    import klirq_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    ////////////////////////////////////////////////////////////////////////
    // First stage is read only by the second stage
    logic [WIDTH-1:0] meta_reg;     // Metastable capture stage
    logic [WIDTH-1:0] stable_reg;   // Settled stage

    // Chain of two flops; outputs are safe for any logic
    // No reset: the chain fills with true pin levels while reset is held,
    // so release never shows a false level to the detectors
    always_ff @(posedge aclk) begin
        meta_reg   <= async_in;
        stable_reg <= meta_reg;
    end

    assign sync_out = stable_reg;

endmodule

// *** logic/klirq_unit.sv ***
`timescale 1ns/1ns
module klirq_unit
    import klirq_pkg::*;
#(
    parameter int LINES = 8,    // Keyboard lines on the port
    parameter int AW    = 12    // AXI byte address width
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write address
    input  wire logic [AW-1:0]    s_axi_awaddr,
    input  wire logic [2:0]       s_axi_awprot,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [AW-1:0]    s_axi_araddr,
    input  wire logic [2:0]       s_axi_arprot,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Port pins and results
    input  wire logic [LINES-1:0] port_one_lines,
    output logic [LINES-1:0]      port_one_lines_sync,
    output logic                  kbd_irq,
    output logic                  wake_req,
    output logic                  irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [LINES-1:0] lines_sync;   // Pins after two flops

    // Pins are asynchronous; detect only on synced copies
    klirq_sync #(
        .WIDTH    (LINES)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (port_one_lines),
        .sync_out (lines_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [LINES-1:0] line_level_select_reg;   // Detection polarity
    logic [LINES-1:0] line_irq_enable_reg;     // Per-line request gate
    logic [LINES-1:0] line_event_flags_reg;    // Sticky line flags
    logic [1:0]       irq_status_reg;          // Sticky block events
    logic [1:0]       irq_mask_reg;            // Event mask
    logic             keypad_global_irq_enable_reg; // Global gate
    logic [LINES-1:0] lines_state_reg;         // Pins seen as plain I/O

    ////////////////////////////////////////////////////////////////////////
    // Write channel holding state
    logic             aw_held_reg;   // Write address captured
    logic             w_held_reg;    // Write data captured
    logic [AW-1:0]    waddr_reg;     // Captured write address
    logic [31:0]      wdata_reg;     // Captured write data
    logic [3:0]       wstrb_reg;     // Captured strobes
    logic             awready_reg;
    logic             wready_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read channel state
    logic             arready_reg;
    logic             rvalid_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    logic             wr_fire;       // Both halves present, do write
    logic             rd_fire;       // Read address taken
    logic [7:0]       widx;          // Write register index
    logic [7:0]       ridx;          // Read register index
    logic             wr_lane0;      // Low byte lane written
    logic             wr_mapped;     // Write hits a register
    logic             rd_mapped;     // Read hits a register

    assign wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_fire  = s_axi_arvalid && arready_reg;
    assign widx     = waddr_reg[9:2];
    assign ridx     = s_axi_araddr[9:2];
    assign wr_lane0 = wstrb_reg[0];

    // Only index space below 0x400 bytes answers OKAY; register writes decode the index alone
    assign wr_mapped = (waddr_reg[AW-1:10] == '0) &&
                       (widx == KLIRQ_IDX_LEVEL   ||
                        widx == KLIRQ_IDX_ENABLE  ||
                        widx == KLIRQ_IDX_FLAGS   ||
                        widx == KLIRQ_IDX_STATUS  ||
                        widx == KLIRQ_IDX_MASK    ||
                        widx == KLIRQ_IDX_CONTROL ||
                        widx == KLIRQ_IDX_LINES);
    assign rd_mapped = (s_axi_araddr[AW-1:10] == '0) &&
                       (ridx == KLIRQ_IDX_LEVEL   ||
                        ridx == KLIRQ_IDX_ENABLE  ||
                        ridx == KLIRQ_IDX_FLAGS   ||
                        ridx == KLIRQ_IDX_STATUS  ||
                        ridx == KLIRQ_IDX_MASK    ||
                        ridx == KLIRQ_IDX_CONTROL ||
                        ridx == KLIRQ_IDX_LINES);

    ////////////////////////////////////////////////////////////////////////
    // Level detection and request terms
    logic [LINES-1:0] level_hit;     // Line shows its programmed level
    logic [LINES-1:0] gated_flags;   // Flags passed by their enables
    logic             kbd_req;       // Combined request before register
    logic             wake_now;      // Enabled line detecting now

    // Set bit selects high, clear bit selects low
    assign level_hit   = ~(lines_sync ^ line_level_select_reg);
    // Each enable passes only its own flag
    assign gated_flags = line_event_flags_reg & line_irq_enable_reg;
    // All lines merge, then the global gate
    assign kbd_req     = (|gated_flags) &&
                         keypad_global_irq_enable_reg;
    // Wake ignores the global gate so a sleeping core still exits
    assign wake_now    = |(level_hit & line_irq_enable_reg);

    ////////////////////////////////////////////////////////////////////////
    // Flag clear terms
    logic [LINES-1:0] rd_clear;      // Bits cleared by a flag read
    logic [LINES-1:0] wr_keep;       // Bits kept by a flag write
    logic [LINES-1:0] wr_load;       // Bits loaded by a flag write

    always_comb begin
        rd_clear = '0;
        wr_keep  = '1;
        wr_load  = '0;
        // Read clears every line but the software-cleared one
        if (rd_fire && rd_mapped && ridx == KLIRQ_IDX_FLAGS) begin
            rd_clear = '1;
            rd_clear[KLIRQ_SW_CLR_LINE] = 1'b0;
        end
        // Write loads the flags, how line 2 gets cleared
        if (wr_fire && wr_lane0 && widx == KLIRQ_IDX_FLAGS) begin
            wr_keep = '0;
            wr_load = wdata_reg[LINES-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line flags: a detection in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_event_flags_reg <= KLIRQ_RST_FLAGS;
        end else begin
            line_event_flags_reg <= ((line_event_flags_reg & wr_keep) |
                                     wr_load) & ~rd_clear
                                    | level_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_level_select_reg        <= KLIRQ_RST_LEVEL;
            line_irq_enable_reg          <= KLIRQ_RST_ENABLE;
            irq_mask_reg                 <= KLIRQ_RST_EVENTS;
            keypad_global_irq_enable_reg <= KLIRQ_RST_GLOBAL;
        end else if (wr_fire && wr_lane0) begin
            case (widx)
                KLIRQ_IDX_LEVEL: begin
                    line_level_select_reg <= wdata_reg[LINES-1:0];
                end
                KLIRQ_IDX_ENABLE: begin
                    line_irq_enable_reg <= wdata_reg[LINES-1:0];
                end
                KLIRQ_IDX_MASK: begin
                    irq_mask_reg <= wdata_reg[1:0];
                end
                KLIRQ_IDX_CONTROL: begin
                    keypad_global_irq_enable_reg <=
                        wdata_reg[KLIRQ_CTL_GLOBAL];
                end
                default: begin
                    // Other indices have no stored config
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain I/O view of every line, enabled or not; flags also record disabled lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lines_state_reg <= '0;
        end else begin
            lines_state_reg <= lines_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Block events: sticky, write one to clear, set wins
    logic             kbd_irq_reg;    // Registered keyboard request
    logic             wake_reg;       // Registered wake
    logic [1:0]       ev_set;         // Events this cycle
    logic [1:0]       ev_clr;         // Software clear this cycle

    assign ev_set[KLIRQ_EV_REQ]  = kbd_req && !kbd_irq_reg;
    assign ev_set[KLIRQ_EV_WAKE] = wake_now && !wake_reg;
    assign ev_clr = (wr_fire && wr_lane0 && widx == KLIRQ_IDX_STATUS) ?
                    wdata_reg[1:0] : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= KLIRQ_RST_EVENTS;
        end else begin
            irq_status_reg <= (irq_status_reg & ~ev_clr) | ev_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic             irq_reg;
    logic [1:0]       status_next;    // Status as it will be next cycle

    assign status_next = (irq_status_reg & ~ev_clr) | ev_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kbd_irq_reg <= 1'b0;
            wake_reg    <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            kbd_irq_reg <= kbd_req;
            wake_reg    <= wake_now;
            // Follows the status register in the same cycle
            irq_reg     <= |(status_next & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write address capture; accepted independently of data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            waddr_reg   <= '0;
        end else if (s_axi_awvalid && awready_reg) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            waddr_reg   <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            // Reopen only after the response has gone
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else if (s_axi_wvalid && wready_reg) begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= KLIRQ_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? KLIRQ_RESP_OKAY : KLIRQ_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data selection
    logic [31:0]      rd_value;       // Word for the addressed register

    always_comb begin
        rd_value = 32'h0000_0000;
        case (ridx)
            KLIRQ_IDX_LEVEL:   rd_value[LINES-1:0] = line_level_select_reg;
            KLIRQ_IDX_ENABLE:  rd_value[LINES-1:0] = line_irq_enable_reg;
            // Value returned is the one before the read clears it
            KLIRQ_IDX_FLAGS:   rd_value[LINES-1:0] = line_event_flags_reg;
            KLIRQ_IDX_STATUS:  rd_value[1:0] = irq_status_reg;
            KLIRQ_IDX_MASK:    rd_value[1:0] = irq_mask_reg;
            KLIRQ_IDX_CONTROL: rd_value[KLIRQ_CTL_GLOBAL] =
                                   keypad_global_irq_enable_reg;
            KLIRQ_IDX_LINES:   rd_value[LINES-1:0] = lines_state_reg;
            default:           rd_value = 32'h0000_0000;
        endcase
        if (!rd_mapped) begin
            rd_value = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel; one read in flight, address refused meanwhile
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= KLIRQ_RESP_OKAY;
        end else if (rd_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_value;
            rresp_reg   <= rd_mapped ? KLIRQ_RESP_OKAY : KLIRQ_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port drive
    assign s_axi_awready       = awready_reg;
    assign s_axi_wready        = wready_reg;
    assign s_axi_bvalid        = bvalid_reg;
    assign s_axi_bresp         = bresp_reg;
    assign s_axi_arready       = arready_reg;
    assign s_axi_rvalid        = rvalid_reg;
    assign s_axi_rdata         = rdata_reg;
    assign s_axi_rresp         = rresp_reg;
    assign port_one_lines_sync = lines_state_reg;
    assign kbd_irq             = kbd_irq_reg;
    assign wake_req            = wake_reg;
    assign irq                 = irq_reg;

endmodule

// *** sim/klirq_sva.sv ***
`timescale 1ns/1ns
// Port-level checks for the keyboard line interrupt unit
module klirq_sva
    import klirq_pkg::*;
#(
    parameter int LINES = 8  // Keyboard lines
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [LINES-1:0] port_one_lines,
    input wire logic [LINES-1:0] port_one_lines_sync,
    input wire logic             kbd_irq,
    input wire logic             wake_req,
    input wire logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] up_cnt; // Edges since reset; sync chain is full at 3
    // Saturating age counter, so the pin chain is not judged while filling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence write_answer;
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endsequence
    rst_idle_a: assert property ($rose(aresetn) |-> !kbd_irq && !irq
        && !wake_req && !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
        else $error("outputs not idle after reset");
    sync_lat_a: assert property (up_cnt == 2'h3
        |-> port_one_lines_sync == $past(port_one_lines, 3))
        else $error("pin view not three edges behind pins");
    write_walk_a: assert property (both_taken |=> write_answer)
        else $error("write answer out of step");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channels not freed after response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    refused_zero_a: assert property (s_axi_rvalid
        && s_axi_rresp == KLIRQ_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    irq_fall_a: assert property ($fell(kbd_irq) |-> !$past(s_axi_arready)
        || !$past(s_axi_arready, 2) || $past(s_axi_bvalid))
        else $error("keyboard request dropped without software access");
endmodule
bind klirq_unit klirq_sva #(.LINES(LINES)) u_sva (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_one_lines, .port_one_lines_sync, .kbd_irq, .wake_req, .irq);

// *** sim/klirq_keys.sv ***
`timescale 1ns/1ns
// Key switches on the port lines; an open key shows its pull level
module klirq_keys (
    input  wire logic [7:0] key_down,   // Keys held closed by the bench
    input  wire logic [7:0] make_level, // Level a closed key drives
    output logic      [7:0] lines       // Pin levels seen by the unit
);
    // Open key reads the inverse level, so a released line does not detect while the level select equals make_level
    always_comb begin
        lines = (key_down & make_level) | (~key_down & ~make_level);
    end
endmodule

// *** sim/klirq_unit_test.sv ***
`timescale 1ns/1ns
module klirq_unit_test
    import klirq_pkg::*;
;
    logic        aclk, aresetn, kbd_irq, wake_req, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;     // Byte addresses
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [2:0]  s_axi_awprot, s_axi_arprot;     // Ignored by the unit
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  key_down, make_level, lines, lines_sync;
    int          err_total, num_checks, cyc;
    klirq_unit uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .port_one_lines(lines),
        .port_one_lines_sync(lines_sync), .kbd_irq, .wake_req, .irq);
    klirq_keys keys (.key_down, .make_level, .lines);
    always #5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////
    // Hang guard: about 150 cycles are expected
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end
    task automatic check(input string nm, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // Write; both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= {2'b00, idx, 2'b00};
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check("bresp", 32'(er), 32'(s_axi_bresp));
    endtask
    // Read; ready is raised late so the slave must hold its answer
    task automatic rd(input logic [7:0] idx, ev, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        check("rdata", {24'h00_0000, ev}, s_axi_rdata);
        check("rresp", 32'(er), 32'(s_axi_rresp));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values and refused addresses
    task automatic reset_test();
        rd(KLIRQ_IDX_LEVEL, 8'h00, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_ENABLE, 8'h00, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_FLAGS, 8'h00, KLIRQ_RESP_OKAY);
        rd(8'h50, 8'h00, KLIRQ_RESP_SLVERR);
        wr(8'h50, 8'hff, KLIRQ_RESP_SLVERR);
        check("kbd_irq", 32'h0, 32'(kbd_irq));
        $display("reset test done");
    endtask
    // Level detection, read clear, line 2 software clear, re-set
    task automatic detect_test();
        make_level <= 8'h0f;
        wr(KLIRQ_IDX_LEVEL, 8'h0f, KLIRQ_RESP_OKAY);
        repeat (4) @(posedge aclk);
        wr(KLIRQ_IDX_FLAGS, 8'h00, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_FLAGS, 8'h00, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_LINES, 8'hf0, KLIRQ_RESP_OKAY);
        check("pin view", 32'h00f0, 32'(lines_sync));
        key_down <= 8'hff;
        repeat (2) @(posedge aclk);
        key_down <= 8'h00;
        repeat (4) @(posedge aclk);
        rd(KLIRQ_IDX_FLAGS, 8'hff, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_FLAGS, 8'h04, KLIRQ_RESP_OKAY);
        wr(KLIRQ_IDX_FLAGS, 8'h00, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_FLAGS, 8'h00, KLIRQ_RESP_OKAY);
        key_down <= 8'h20;
        repeat (4) @(posedge aclk);
        rd(KLIRQ_IDX_FLAGS, 8'h20, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_FLAGS, 8'h20, KLIRQ_RESP_OKAY);
        key_down <= 8'h00;
        repeat (4) @(posedge aclk);
        rd(KLIRQ_IDX_FLAGS, 8'h20, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_FLAGS, 8'h00, KLIRQ_RESP_OKAY);
        $display("detect test done");
    endtask
    // Per-line and global gating, wake, status and mask
    task automatic irq_test();
        wr(KLIRQ_IDX_CONTROL, 8'h01, KLIRQ_RESP_OKAY);
        wr(KLIRQ_IDX_ENABLE, 8'h20, KLIRQ_RESP_OKAY);
        key_down <= 8'h08;
        repeat (5) @(posedge aclk);
        check("kbd_irq", 32'h0, 32'(kbd_irq));
        check("wake_req", 32'h0, 32'(wake_req));
        wr(KLIRQ_IDX_ENABLE, 8'h28, KLIRQ_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("wake_req", 32'h1, 32'(wake_req));
        check("kbd_irq", 32'h1, 32'(kbd_irq));
        wr(KLIRQ_IDX_CONTROL, 8'h00, KLIRQ_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("kbd_irq", 32'h0, 32'(kbd_irq));
        wr(KLIRQ_IDX_CONTROL, 8'h01, KLIRQ_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("kbd_irq", 32'h1, 32'(kbd_irq));
        rd(KLIRQ_IDX_STATUS, 8'h03, KLIRQ_RESP_OKAY);
        check("irq", 32'h0, 32'(irq));
        wr(KLIRQ_IDX_MASK, 8'h01, KLIRQ_RESP_OKAY);
        @(posedge aclk);
        check("irq", 32'h1, 32'(irq));
        wr(KLIRQ_IDX_STATUS, 8'h01, KLIRQ_RESP_OKAY);
        rd(KLIRQ_IDX_STATUS, 8'h02, KLIRQ_RESP_OKAY);
        check("irq", 32'h0, 32'(irq));
        key_down <= 8'h00;
        repeat (4) @(posedge aclk);
        rd(KLIRQ_IDX_FLAGS, 8'h08, KLIRQ_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("kbd_irq", 32'h0, 32'(kbd_irq));
        check("wake_req", 32'h0, 32'(wake_req));
        $display("irq test done");
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        key_down = 8'h00;
        make_level = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        reset_test();
        detect_test();
        irq_test();
        results();
    end
endmodule
